//--- verilog/phy_pcs_status_control_regs.sv
// Purpose: coding-sublayer control and status registers on an AHB-Lite slave
// Assumes: live status inputs come from logic on hclk; word transfers only
// Notes:   writes have no wait state, reads insert one wait state
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module phy_pcs_status_control_regs #(
    parameter int USER_W = 7
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic      [1:0]        hresp,
    input  wire logic [USER_W-1:0] partner_user_value,
    input  wire logic              partner_oam_capable,
    input  wire logic              partner_energy_saving_capable,
    input  wire logic              tx_idle_now,
    input  wire logic              rx_idle_now,
    input  wire logic              sublayer_fault_now,
    input  wire logic              rx_link_up_now,
    input  wire logic              high_error_rate_now,
    input  wire logic              block_lock_now,
    output logic      [2:0]        test_mode,
    output logic                   sublayer_reset,
    output logic                   sublayer_loopback_enable
);

    // bus capture
    logic                           wr_pend_r;
    logic                           rd_pend_r;
    logic [pcs_regs_pkg::IDX_W-1:0] idx_r;
    logic [pcs_regs_pkg::IDX_W-1:0] addr_idx;
    logic                           accept;
    logic                           hit_partner;
    logic                           hit_test;
    logic                           hit_mirror;
    logic                           hit_control;
    logic                           hit_state;
    logic                           hit_ext;
    logic                           wr_test;
    logic                           wr_ctl_any;
    logic                           wr_state;
    logic                           wr_ext;
    logic [15:0]                    wd;

    // control and latched state
    logic [2:0]                     test_mode_r;
    logic [2:0]                     test_mode_nxt;
    logic                           reset_pulse_r;
    logic                           loopback_r;
    logic                           loopback_nxt;
    logic                           tx_idle_lh_r;
    logic                           rx_idle_lh_r;
    logic                           link_ll_r;
    logic                           hiber_lh_r;
    logic                           lock_ll_r;
    logic                           tx_idle_lh_nxt;
    logic                           rx_idle_lh_nxt;
    logic                           link_ll_nxt;
    logic                           hiber_lh_nxt;
    logic                           lock_ll_nxt;

    // read data
    logic [15:0]                    rd_partner;
    logic [15:0]                    rd_test;
    logic [15:0]                    rd_control;
    logic [15:0]                    rd_state;
    logic [15:0]                    rd_ext;
    logic [15:0]                    rd_word;
    logic [31:0]                    hrdata_r;
    logic                           hreadyout_r;
    logic [1:0]                     hresp_r;

    // index is the byte address over four
    assign addr_idx = haddr[pcs_regs_pkg::IDX_W+1:2];
    assign accept   = hsel && hready && (htrans == pcs_regs_pkg::HTRANS_NONSEQ);

    // space nibble first, then the low twelve bits
    assign hit_partner = (idx_r[15:12] == pcs_regs_pkg::MMD_PMA) &&
                         (idx_r[11:0] == pcs_regs_pkg::LOC_PARTNER);
    assign hit_test    = (idx_r[15:12] == pcs_regs_pkg::MMD_PMA) &&
                         (idx_r[11:0] == pcs_regs_pkg::LOC_TEST);
    assign hit_mirror  = (idx_r[15:12] == pcs_regs_pkg::MMD_PCS) &&
                         (idx_r[11:0] == pcs_regs_pkg::LOC_MIRROR);
    assign hit_control = (idx_r[15:12] == pcs_regs_pkg::MMD_PCS) &&
                         (idx_r[11:0] == pcs_regs_pkg::LOC_CONTROL);
    assign hit_state   = (idx_r[15:12] == pcs_regs_pkg::MMD_PCS) &&
                         (idx_r[11:0] == pcs_regs_pkg::LOC_STATE);
    assign hit_ext     = (idx_r[15:12] == pcs_regs_pkg::MMD_PCS) &&
                         (idx_r[11:0] == pcs_regs_pkg::LOC_STATE_EXT);

    assign wd         = hwdata[15:0];
    assign wr_test    = wr_pend_r && hit_test;
    assign wr_ctl_any = wr_pend_r && (hit_control || hit_mirror);
    assign wr_state   = wr_pend_r && hit_state;
    assign wr_ext     = wr_pend_r && hit_ext;

    // reserved test code is not taken
    assign test_mode_nxt =
        (wr_test && (wd[pcs_regs_pkg::POS_TEST_HI:pcs_regs_pkg::POS_TEST_LO]
                     != pcs_regs_pkg::TEST_RESERVED))
        ? wd[pcs_regs_pkg::POS_TEST_HI:pcs_regs_pkg::POS_TEST_LO]
        : test_mode_r;

    assign loopback_nxt = wr_ctl_any ? wd[pcs_regs_pkg::POS_LOOPBACK]
                                     : loopback_r;

    // latched high: event wins over the clearing write
    assign tx_idle_lh_nxt = tx_idle_now ||
        (tx_idle_lh_r && !(wr_state && !wd[pcs_regs_pkg::POS_TX_IDLE_LH]));
    assign rx_idle_lh_nxt = rx_idle_now ||
        (rx_idle_lh_r && !(wr_state && !wd[pcs_regs_pkg::POS_RX_IDLE_LH]));
    assign hiber_lh_nxt   = high_error_rate_now ||
        (hiber_lh_r && !(wr_ext && !wd[pcs_regs_pkg::POS_HIBER_LH]));

    // latched low: loss wins over the restoring write
    assign link_ll_nxt = rx_link_up_now &&
        (link_ll_r || (wr_state && !wd[pcs_regs_pkg::POS_LINK_LL]));
    assign lock_ll_nxt = block_lock_now &&
        (lock_ll_r || (wr_ext && !wd[pcs_regs_pkg::POS_LOCK_LL]));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r   <= 1'b0;
            rd_pend_r   <= 1'b0;
            idx_r       <= pcs_regs_pkg::RST_ALL;
            hreadyout_r <= 1'b1;
            hresp_r     <= pcs_regs_pkg::HRESP_OKAY;
        end else begin
            hresp_r     <= pcs_regs_pkg::HRESP_OKAY;
            wr_pend_r   <= accept && hwrite;
            rd_pend_r   <= accept && !hwrite;
            hreadyout_r <= !(accept && !hwrite);
            if (accept) begin
                idx_r <= addr_idx;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            test_mode_r   <= pcs_regs_pkg::RST_TEST_MODE;
            reset_pulse_r <= 1'b0;
            loopback_r    <= 1'b0;
        end else begin
            test_mode_r   <= test_mode_nxt;
            reset_pulse_r <= wr_ctl_any && wd[pcs_regs_pkg::POS_SL_RESET];
            loopback_r    <= loopback_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_idle_lh_r <= 1'b0;
            rx_idle_lh_r <= 1'b0;
            link_ll_r    <= 1'b0;
            hiber_lh_r   <= 1'b0;
            lock_ll_r    <= 1'b0;
        end else begin
            tx_idle_lh_r <= tx_idle_lh_nxt;
            rx_idle_lh_r <= rx_idle_lh_nxt;
            link_ll_r    <= link_ll_nxt;
            hiber_lh_r   <= hiber_lh_nxt;
            lock_ll_r    <= lock_ll_nxt;
        end
    end

    // read words; reserved bits read zero
    always_comb begin
        rd_partner = pcs_regs_pkg::RST_ALL;
        rd_partner[pcs_regs_pkg::POS_USER_HI:pcs_regs_pkg::POS_USER_LO] =
            partner_user_value;
        rd_partner[pcs_regs_pkg::POS_OAM] = partner_oam_capable;
        rd_partner[pcs_regs_pkg::POS_EEE] = partner_energy_saving_capable;
    end

    always_comb begin
        rd_test = pcs_regs_pkg::RST_ALL;
        rd_test[pcs_regs_pkg::POS_TEST_HI:pcs_regs_pkg::POS_TEST_LO] = test_mode_r;
    end

    // reset bit always reads zero
    always_comb begin
        rd_control = pcs_regs_pkg::RST_ALL;
        rd_control[pcs_regs_pkg::POS_LOOPBACK] = loopback_r;
    end

    always_comb begin
        rd_state = pcs_regs_pkg::RST_ALL;
        rd_state[pcs_regs_pkg::POS_TX_IDLE_LH] = tx_idle_lh_r;
        rd_state[pcs_regs_pkg::POS_RX_IDLE_LH] = rx_idle_lh_r;
        rd_state[pcs_regs_pkg::POS_TX_IDLE]    = tx_idle_now;
        rd_state[pcs_regs_pkg::POS_RX_IDLE]    = rx_idle_now;
        rd_state[pcs_regs_pkg::POS_FAULT]      = sublayer_fault_now;
        rd_state[pcs_regs_pkg::POS_LINK_LL]    = link_ll_r;
    end

    always_comb begin
        rd_ext = pcs_regs_pkg::RST_ALL;
        rd_ext[pcs_regs_pkg::POS_LINK_NOW]  = rx_link_up_now;
        rd_ext[pcs_regs_pkg::POS_HIBER_NOW] = high_error_rate_now;
        rd_ext[pcs_regs_pkg::POS_LOCK_NOW]  = block_lock_now;
        rd_ext[pcs_regs_pkg::POS_HIBER_LH]  = hiber_lh_r;
        rd_ext[pcs_regs_pkg::POS_LOCK_LL]   = lock_ll_r;
    end

    // unmapped reads return zero
    assign rd_word = hit_partner ? rd_partner :
                     hit_test    ? rd_test    :
                     (hit_control || hit_mirror) ? rd_control :
                     hit_state   ? rd_state   :
                     hit_ext     ? rd_ext     : pcs_regs_pkg::RST_ALL;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_pend_r) begin
            hrdata_r <= {16'h0000, rd_word};
        end
    end

    assign hrdata                   = hrdata_r;
    assign hreadyout                = hreadyout_r;
    assign hresp                    = hresp_r;
    assign test_mode                = test_mode_r;
    assign sublayer_reset           = reset_pulse_r;
    assign sublayer_loopback_enable = loopback_r;

endmodule

`default_nettype wire

//--- pkg/pcs_regs_pkg.sv
// Purpose: constants for the coding-sublayer management register slice
// Assumes: register indices are printed offsets; byte address = 4 * index
// Notes:   top index nibble names the MMD space, low twelve bits the register
package pcs_regs_pkg;

    localparam int          IDX_W          = 16;
    localparam int          LOC_W          = 12;
    localparam int          DATA_W         = 16;

    localparam logic [3:0]  MMD_PMA        = 4'h1;
    localparam logic [3:0]  MMD_PCS        = 4'h3;

    localparam logic [11:0] LOC_PARTNER    = 12'h903;
    localparam logic [11:0] LOC_TEST       = 12'h904;
    localparam logic [11:0] LOC_MIRROR     = 12'h000;
    localparam logic [11:0] LOC_CONTROL    = 12'h900;
    localparam logic [11:0] LOC_STATE      = 12'h901;
    localparam logic [11:0] LOC_STATE_EXT  = 12'h902;

    localparam logic [15:0] IDX_PARTNER    = 16'h1903;
    localparam logic [15:0] IDX_TEST       = 16'h1904;
    localparam logic [15:0] IDX_MIRROR     = 16'h3000;
    localparam logic [15:0] IDX_CONTROL    = 16'h3900;
    localparam logic [15:0] IDX_STATE      = 16'h3901;
    localparam logic [15:0] IDX_STATE_EXT  = 16'h3902;

    localparam logic [15:0] RST_ALL        = 16'h0000;
    localparam logic [2:0]  RST_TEST_MODE  = 3'h0;
    localparam logic [2:0]  TEST_RESERVED  = 3'h3;

    // partner training info fields
    localparam int          POS_USER_LO    = 4;
    localparam int          POS_USER_HI    = 10;
    localparam int          POS_OAM        = 1;
    localparam int          POS_EEE        = 0;
    // test pattern select field
    localparam int          POS_TEST_LO    = 13;
    localparam int          POS_TEST_HI    = 15;
    // control and mirror
    localparam int          POS_SL_RESET   = 15;
    localparam int          POS_LOOPBACK   = 14;
    // coding sublayer state
    localparam int          POS_TX_IDLE_LH = 11;
    localparam int          POS_RX_IDLE_LH = 10;
    localparam int          POS_TX_IDLE    = 9;
    localparam int          POS_RX_IDLE    = 8;
    localparam int          POS_FAULT      = 7;
    localparam int          POS_LINK_LL    = 2;
    // coding sublayer state ext
    localparam int          POS_LINK_NOW   = 10;
    localparam int          POS_HIBER_NOW  = 9;
    localparam int          POS_LOCK_NOW   = 8;
    localparam int          POS_HIBER_LH   = 7;
    localparam int          POS_LOCK_LL    = 6;

    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic [1:0]  HRESP_OKAY     = 2'h0;

endpackage

//--- tb/phy_pcs_status_control_regs_checker.sv
// Purpose: bus timing and register effects of the coding-sublayer slice
// Assumes: one master, word transfers, hready from this slave
// Notes:   bound to every instance of the register slice
`timescale 1ns/100ps
`default_nettype none
module phy_pcs_status_control_regs_checker #(
    parameter int USER_W = 7
) (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic              hreadyout,
    input wire logic [USER_W-1:0] partner_user_value,
    input wire logic              partner_oam_capable,
    input wire logic              partner_energy_saving_capable,
    input wire logic              rx_link_up_now,
    input wire logic              high_error_rate_now,
    input wire logic              block_lock_now,
    input wire logic [2:0]        test_mode,
    input wire logic              sublayer_reset,
    input wire logic              sublayer_loopback_enable
);
    wire logic        take = hsel && hready && htrans == pcs_regs_pkg::HTRANS_NONSEQ;
    wire logic [15:0] idx  = haddr[17:2];
    wire logic        ctl  = idx == pcs_regs_pkg::IDX_CONTROL || idx == pcs_regs_pkg::IDX_MIRROR;
    wire logic        tst  = take && hwrite && idx == pcs_regs_pkg::IDX_TEST;
    wire logic        bad  = idx[15:12] != pcs_regs_pkg::MMD_PMA && idx[15:12] != pcs_regs_pkg::MMD_PCS;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not one wait state");
    a_reset_pulse: assert property (take && hwrite && ctl ##1 hwdata[15] |=> sublayer_reset ##1 !sublayer_reset)
        else $error("sublayer reset pulse missing or too long");
    a_pulse_cause: assert property ($rose(sublayer_reset) |-> $past(hwdata[15]))
        else $error("sublayer reset without a write of bit 15");
    a_loop_follow: assert property (take && hwrite && ctl ##1 1'b1 |=> sublayer_loopback_enable == $past(hwdata[14]))
        else $error("loopback enable does not follow write");
    a_test_store: assert property (tst ##1 hwdata[15:13] != pcs_regs_pkg::TEST_RESERVED |=> test_mode == $past(hwdata[15:13]))
        else $error("test mode not stored");
    a_test_refuse: assert property (tst ##1 hwdata[15:13] == pcs_regs_pkg::TEST_RESERVED |=> $stable(test_mode))
        else $error("reserved test mode code stored");
    a_partner_read: assert property (take && !hwrite && idx == pcs_regs_pkg::IDX_PARTNER ##1 1'b1 |=> hrdata == {21'h0, $past(partner_user_value), 2'h0, $past(partner_oam_capable), $past(partner_energy_saving_capable)})
        else $error("partner training word wrong");
    a_ext_live: assert property (take && !hwrite && idx == pcs_regs_pkg::IDX_STATE_EXT ##1 1'b1 |=> hrdata[10:8] == {$past(rx_link_up_now), $past(high_error_rate_now), $past(block_lock_now)})
        else $error("live link, error rate or lock bits wrong");
    a_space_zero: assert property (take && !hwrite && bad ##1 1'b1 |=> hrdata == 32'h0)
        else $error("read outside the two spaces not zero");
endmodule
bind phy_pcs_status_control_regs phy_pcs_status_control_regs_checker #(.USER_W(USER_W)) u_checker (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .partner_user_value(partner_user_value), .partner_oam_capable(partner_oam_capable),
    .partner_energy_saving_capable(partner_energy_saving_capable),
    .rx_link_up_now(rx_link_up_now), .high_error_rate_now(high_error_rate_now),
    .block_lock_now(block_lock_now), .test_mode(test_mode), .sublayer_reset(sublayer_reset),
    .sublayer_loopback_enable(sublayer_loopback_enable));
`default_nettype wire

//--- tb/tb_phy_pcs_status_control_regs.sv
// Purpose: self-checking bench for the coding-sublayer register slice
// Assumes: byte address is four times the register index
// Notes:   status inputs are driven directly, same clock
`timescale 1ns/100ps
`default_nettype none
module tb_phy_pcs_status_control_regs;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0]  htrans = 2'h0;
    logic [6:0]  user_val = 7'h0;
    logic        oam = 1'b0, eee = 1'b0, tx_idle = 1'b0, rx_idle = 1'b0;
    logic        fault = 1'b0, link = 1'b0, hiber = 1'b0, lock = 1'b0;
    wire logic [31:0] hrdata;
    wire logic [1:0]  hresp;
    wire logic [2:0]  test_mode;
    wire logic        hreadyout, sreset, loop_en;
    int          err_count = 0, tests_run = 0, pulses = 0;
    localparam logic [31:0] A_PART = 32'h0000640C, A_TEST = 32'h00006410, A_MIRR = 32'h0000C000;
    localparam logic [31:0] A_CTRL = 32'h0000E400, A_STAT = 32'h0000E404, A_EXT = 32'h0000E408;
    logic [31:0] addrs [6] = '{A_PART, A_TEST, A_MIRR, A_CTRL, A_STAT, A_EXT};
    phy_pcs_status_control_regs u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .partner_user_value(user_val),
        .partner_oam_capable(oam), .partner_energy_saving_capable(eee), .tx_idle_now(tx_idle),
        .rx_idle_now(rx_idle), .sublayer_fault_now(fault), .rx_link_up_now(link),
        .high_error_rate_now(hiber), .block_lock_now(lock), .test_mode(test_mode),
        .sublayer_reset(sreset), .sublayer_loopback_enable(loop_en));
    always #4 hclk = ~hclk;
    always @(posedge hclk) if (sreset === 1'b1) pulses <= pulses + 1;
    task automatic final_report;
        if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // address phase held until hready, then data phase held until hready
    task automatic xfer(input logic [31:0] a, input logic wr, input logic [15:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= pcs_regs_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", {30'h0, hresp}, {30'h0, pcs_regs_pkg::HRESP_OKAY});
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rdc(input string name, input logic [31:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 16'h0);
        chk(name, rd, exp);
    endtask
    task automatic t_reset;
        foreach (addrs[i]) rdc("reset value", addrs[i], 32'h0);
    endtask
    task automatic t_partner;
        user_val <= 7'h5A;
        oam      <= 1'b1;
        @(posedge hclk);
        rdc("partner", A_PART, 32'h000005A2);
        wr(A_PART, 16'hFFFF);
        user_val <= 7'h25;
        oam      <= 1'b0;
        eee      <= 1'b1;
        @(posedge hclk);
        rdc("partner", A_PART, 32'h00000251);
    endtask
    task automatic t_test;
        logic [2:0] exp;
        exp = 3'h0;
        for (int i = 0; i < 8; i++) begin
            wr(A_TEST, 16'(i << 13));
            if (i != 3) exp = 3'(i);
            rdc("test select", A_TEST, {16'h0, exp, 13'h0});
            chk("test_mode", {29'h0, test_mode}, {29'h0, exp});
        end
    endtask
    task automatic t_control;
        int p0;
        p0 = pulses;
        wr(A_CTRL, 16'hC000);
        rdc("control", A_CTRL, 32'h00004000);
        chk("loopback", {31'h0, loop_en}, 32'h1);
        wr(A_MIRR, 16'h8000);
        rdc("mirror", A_MIRR, 32'h0);
        rdc("control", A_CTRL, 32'h0);
        chk("pulses", 32'(pulses - p0), 32'h2);
        wr(A_MIRR, 16'h4000);
        rdc("control", A_CTRL, 32'h00004000);
    endtask
    task automatic t_latch_high;
        {tx_idle, rx_idle, hiber} <= 3'h7;
        @(posedge hclk);
        {tx_idle, rx_idle, hiber} <= 3'h0;
        @(posedge hclk);
        rdc("state", A_STAT, 32'h00000C00);
        wr(A_STAT, 16'hFFFF);
        rdc("state", A_STAT, 32'h00000C00);
        wr(A_STAT, 16'h0);
        rdc("state", A_STAT, 32'h0);
        rdc("ext", A_EXT, 32'h00000080);
        wr(A_EXT, 16'h0);
        rdc("ext", A_EXT, 32'h0);
    endtask
    task automatic t_latch_low;
        {link, lock, fault, rx_idle} <= 4'hF;
        @(posedge hclk);
        rdc("state", A_STAT, 32'h00000580);
        rdc("ext", A_EXT, 32'h00000500);
        wr(A_STAT, 16'h0);
        wr(A_EXT, 16'h0);
        rdc("state", A_STAT, 32'h00000584);
        rdc("ext", A_EXT, 32'h00000540);
        {link, lock} <= 2'h0;
        @(posedge hclk);
        {link, lock} <= 2'h3;
        @(posedge hclk);
        wr(A_EXT, 16'h0040);
        rdc("state", A_STAT, 32'h00000580);
        rdc("ext", A_EXT, 32'h00000500);
    endtask
    task automatic t_space;
        wr(32'h0000E410, 16'h0);
        chk("test_mode", {29'h0, test_mode}, 32'h7);
        rdc("wrong space", 32'h0000E40C, 32'h0);
        rdc("wrong space", 32'h0000A404, 32'h0);
    endtask
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_partner;
        t_test;
        t_control;
        t_latch_high;
        t_latch_low;
        t_space;
        final_report;
    end
    initial begin
        #50000;
        err_count++;
        final_report;
    end
endmodule
`default_nettype wire
